// File: pkg/hfs_consts.svh
// constants for the host fault status and error code block
`ifndef HFS_CONSTS_SVH
`define HFS_CONSTS_SVH
`define HFS_ERR_OFFSET 8'h2E
`define HFS_IRQCFG_OFFSET 8'h07
`define HFS_INTSTAT_OFFSET 8'h2D
`define HFS_FAULT_BIT 7
`define HFS_ERR_RESET 8'h00
`define HFS_ERR_NONE 8'h00
`define HFS_ERR_VERSION 8'h10
`define HFS_ERR_UPL_FIRST 8'h11
`define HFS_ERR_UPL_LAST 8'h17
`define HFS_ERR_WDOG 8'h19
`define HFS_ERR_ROMVER 8'h1A
`define HFS_ERR_FATALFW 8'h1B
`define HFS_ERR_NEXT_MISSING 8'h1C
`define HFS_ERR_PAYLOAD_BAD 8'h1D
`endif

// File: pkg/hfs_pkg.sv
// types for the host fault status and error code block
package hfs_pkg;
	typedef enum logic [1:0] {
		HFS_ST_RESET,
		HFS_ST_WAIT_CFG,
		HFS_ST_RUN
	} hfs_state_e;
	typedef logic [7:0] hfs_byte_t;
endpackage : hfs_pkg

// File: rtl/hfs_fault_status.sv
// reset-or-fault flag, interrupt gating and internal error code register
`timescale 1ns/10ps
`include "hfs_consts.svh"

// Overview of operation
// - a fatal-error interrupt sets bit 7 of the interrupt status word.
// - the flag is set out of reset and cleared when init completes and code starts.
// - after an ordinary reset no interrupt is raised until the host writes the irq config.
// - after a watchdog or fatal reset with retained config, interrupts may be raised at once.
// - the current error code reads at host offset 0x2E, 0x00 meaning no error.
// - fatal error codes are also signalled as an error notification event.
// - upload failures use codes 0x11 to 0x17.
// - firmware version mismatch uses code 0x10, fatal.
// - chained image failures use 0x1C and 0x1D, fatal.
// - the boot stage may raise only bootloader-capable codes; 0x1A never from boot.
module hfs_fault_status (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	input wire logic clk_en,
	// host register access
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	// core side
	input wire logic init_done,
	input wire logic fatal_irq,
	input wire logic err_wr,
	input wire logic [7:0] err_code,
	input wire logic boot_stage,
	input wire logic warm_reset,
	input wire logic cfg_retained,
	input wire logic irq_req,
	// outputs
	output logic reset_fault,
	output logic host_irq,
	output logic err_event,
	output logic [7:0] err_value
);
	hfs_pkg::hfs_state_e st_q, st_d;
	logic flag_q, flag_d;
	logic irq_ok_q, irq_ok_d;
	logic irq_q, irq_d;
	logic ev_q, ev_d;
	logic [7:0] err_q, err_d;
	logic [7:0] rd_q, rd_d;

	// codes the boot stage is allowed to raise
	function automatic logic boot_ok(input logic [7:0] c);
		boot_ok = (c == `HFS_ERR_NONE) || (c == `HFS_ERR_VERSION) ||
			(c >= `HFS_ERR_UPL_FIRST && c <= `HFS_ERR_UPL_LAST) ||
			(c == `HFS_ERR_WDOG) || (c == `HFS_ERR_FATALFW);
	endfunction : boot_ok

	// codes in the fatal category covered here
	function automatic logic is_fatal(input logic [7:0] c);
		is_fatal = 1'b0;
		if (c >= `HFS_ERR_VERSION && c <= `HFS_ERR_UPL_LAST) begin
			is_fatal = 1'b1;
		end
		if (c >= `HFS_ERR_WDOG && c <= `HFS_ERR_PAYLOAD_BAD) begin
			is_fatal = 1'b1;
		end
	endfunction : is_fatal

	logic cfg_wr;
	logic err_take;
	assign cfg_wr = host_wr && (host_addr == `HFS_IRQCFG_OFFSET);
	assign err_take = err_wr && (!boot_stage || boot_ok(err_code));

	// boot sequence and the reset-or-fault flag
	always_comb begin
		st_d = st_q;
		flag_d = flag_q;
		case (st_q)
			hfs_pkg::HFS_ST_RESET: begin
				flag_d = 1'b1;
				st_d = hfs_pkg::HFS_ST_WAIT_CFG;
			end
			hfs_pkg::HFS_ST_WAIT_CFG: begin
				if (init_done) begin
					flag_d = 1'b0;
					st_d = hfs_pkg::HFS_ST_RUN;
				end
			end
			hfs_pkg::HFS_ST_RUN: begin
				if (init_done) begin
					flag_d = 1'b0;
				end
			end
			default: begin
				st_d = hfs_pkg::HFS_ST_RESET;
			end
		endcase
		// a fatal interrupt beats the init clear in the same cycle
		if (fatal_irq) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= hfs_pkg::HFS_ST_RESET;
			flag_q <= 1'b1;
		end else if (clk_en) begin
			st_q <= st_d;
			flag_q <= flag_d;
		end
	end

	// interrupt enable and the registered interrupt line
	always_comb begin
		irq_ok_d = irq_ok_q;
		if (st_q == hfs_pkg::HFS_ST_RESET) begin
			// warm_reset and cfg_retained are sampled after release
			irq_ok_d = warm_reset && cfg_retained;
		end
		if (cfg_wr) begin
			irq_ok_d = 1'b1;
		end
		irq_d = (irq_req || fatal_irq) && irq_ok_d;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_ok_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (clk_en) begin
			irq_ok_q <= irq_ok_d;
			irq_q <= irq_d;
		end
	end

	// error code register and its notification pulse
	always_comb begin
		err_d = err_q;
		ev_d = 1'b0;
		if (err_take) begin
			err_d = err_code;
			ev_d = is_fatal(err_code);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			err_q <= `HFS_ERR_RESET;
			ev_q <= 1'b0;
		end else if (clk_en) begin
			err_q <= err_d;
			ev_q <= ev_d;
		end
	end

	// host read data, registered and held between reads
	always_comb begin
		rd_d = rd_q;
		if (host_rd) begin
			rd_d = 8'h00;
			if (host_addr == `HFS_ERR_OFFSET) begin
				rd_d = err_q;
			end else if (host_addr == `HFS_INTSTAT_OFFSET) begin
				rd_d[`HFS_FAULT_BIT] = flag_q;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_q <= 8'h00;
		end else if (clk_en) begin
			rd_q <= rd_d;
		end
	end

	assign host_rdata = rd_q;
	assign reset_fault = flag_q;
	assign host_irq = irq_q;
	assign err_event = ev_q;
	assign err_value = err_q;

	// checker shadows of the interrupt enable, kept apart from the
	// datapath so a broken enable path above cannot hide from them
	logic chk_cfg_q, chk_cfg_d;
	logic chk_warm_q, chk_warm_d;
	logic chk_first_q, chk_first_d;
	logic chk_en;

	always_comb begin
		chk_cfg_d = chk_cfg_q || cfg_wr;
		chk_warm_d = chk_warm_q ||
			(chk_first_q && warm_reset && cfg_retained);
		chk_first_d = 1'b0;
		chk_en = chk_cfg_d || chk_warm_d;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			chk_cfg_q <= 1'b0;
			chk_warm_q <= 1'b0;
			chk_first_q <= 1'b1;
		end else if (clk_en) begin
			chk_cfg_q <= chk_cfg_d;
			chk_warm_q <= chk_warm_d;
			chk_first_q <= chk_first_d;
		end
	end

	a_irq_gated: assert property (@(posedge mclk) disable iff (srst)
		host_irq |-> irq_ok_q)
		else $error("interrupt raised before enable");
	a_cold_quiet: assert property (@(posedge mclk) disable iff (srst)
		clk_en && !chk_en |=> !host_irq)
		else $error("interrupt before host configuration");
	a_irq_follow: assert property (@(posedge mclk) disable iff (srst)
		clk_en && (irq_req || fatal_irq) && chk_en |=> host_irq)
		else $error("enabled interrupt not raised");
	a_irq_drop: assert property (@(posedge mclk) disable iff (srst)
		clk_en && !irq_req && !fatal_irq |=> !host_irq)
		else $error("interrupt without a request");
	a_fault_set: assert property (@(posedge mclk) disable iff (srst)
		clk_en && fatal_irq |=> reset_fault)
		else $error("fault flag not set on fatal irq");
	a_fault_rise: assert property (@(posedge mclk) disable iff (srst)
		$rose(reset_fault) |-> $past(fatal_irq))
		else $error("fault flag rose without fatal irq");
	a_flag_reset: assert property (@(posedge mclk)
		$fell(srst) |-> reset_fault)
		else $error("flag not set out of reset");
	a_flag_hold: assert property (@(posedge mclk) disable iff (srst)
		clk_en && !init_done && !fatal_irq
		|=> reset_fault == $past(reset_fault))
		else $error("flag changed without cause");
	a_init_clear: assert property (@(posedge mclk) disable iff (srst)
		clk_en && init_done && !fatal_irq && st_q != hfs_pkg::HFS_ST_RESET
		|=> !reset_fault)
		else $error("flag not cleared after init");
	a_reset_leave: assert property (@(posedge mclk) disable iff (srst)
		clk_en && st_q == hfs_pkg::HFS_ST_RESET
		|=> st_q == hfs_pkg::HFS_ST_WAIT_CFG)
		else $error("boot sequence stuck after reset");
	a_reset_values: assert property (@(posedge mclk)
		srst |=> reset_fault && !host_irq && !err_event &&
		err_value == `HFS_ERR_RESET && host_rdata == 8'h00)
		else $error("outputs not at reset values");

	// error register and its event
	a_err_hold: assert property (@(posedge mclk) disable iff (srst)
		!(clk_en && err_take) |=> $stable(err_value))
		else $error("error code changed without write");
	a_err_load: assert property (@(posedge mclk) disable iff (srst)
		clk_en && err_take |=> err_value == $past(err_code))
		else $error("accepted code not stored");
	a_boot_codes: assert property (@(posedge mclk) disable iff (srst)
		clk_en && err_wr && boot_stage && err_code == `HFS_ERR_ROMVER
		|=> err_value != `HFS_ERR_ROMVER || $past(err_value)
		== `HFS_ERR_ROMVER)
		else $error("boot stage raised late-stage code");
	a_boot_reject: assert property (@(posedge mclk) disable iff (srst)
		clk_en && err_wr && boot_stage &&
		(err_code == `HFS_ERR_ROMVER ||
		err_code == `HFS_ERR_NEXT_MISSING ||
		err_code == `HFS_ERR_PAYLOAD_BAD) |=> $stable(err_value))
		else $error("boot stage code not rejected");
	a_err_event: assert property (@(posedge mclk) disable iff (srst)
		err_event |-> is_fatal(err_value))
		else $error("event for non-fatal code");
	a_event_fatal: assert property (@(posedge mclk) disable iff (srst)
		clk_en && err_take && is_fatal(err_code) |=> err_event)
		else $error("fatal code without event");
	a_event_pulse: assert property (@(posedge mclk) disable iff (srst)
		clk_en && !err_take |=> !err_event)
		else $error("event without accepted code");
	a_err_none: assert property (@(posedge mclk) disable iff (srst)
		clk_en && err_take && err_code == `HFS_ERR_NONE |=> !err_event)
		else $error("event for the no-error code");

	// host reads
	a_err_read: assert property (@(posedge mclk) disable iff (srst)
		clk_en && host_rd && host_addr == `HFS_ERR_OFFSET
		|=> host_rdata == $past(err_value))
		else $error("error register read mismatch");
	a_stat_read: assert property (@(posedge mclk) disable iff (srst)
		clk_en && host_rd && host_addr == `HFS_INTSTAT_OFFSET
		|=> host_rdata == {$past(reset_fault), 7'h00})
		else $error("status read mismatch");
	a_other_read: assert property (@(posedge mclk) disable iff (srst)
		clk_en && host_rd && host_addr != `HFS_ERR_OFFSET &&
		host_addr != `HFS_INTSTAT_OFFSET |=> host_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (@(posedge mclk) disable iff (srst)
		clk_en && !host_rd |=> $stable(host_rdata))
		else $error("read data changed without read");
	a_freeze_hold: assert property (@(posedge mclk) disable iff (srst)
		!clk_en |=> $stable(err_value) && $stable(reset_fault) &&
		$stable(host_irq) && $stable(host_rdata))
		else $error("state moved while frozen");

	c_warm_irq: cover property (@(posedge mclk) disable iff (srst)
		warm_reset && cfg_retained ##[1:4] host_irq);
	c_cfg_irq: cover property (@(posedge mclk) disable iff (srst)
		cfg_wr ##[1:8] host_irq);
	c_upload_err: cover property (@(posedge mclk) disable iff (srst)
		err_value == `HFS_ERR_UPL_FIRST);
	c_init: cover property (@(posedge mclk) disable iff (srst)
		$fell(reset_fault));
	c_boot_reject: cover property (@(posedge mclk) disable iff (srst)
		err_wr && boot_stage && !err_take);
endmodule : hfs_fault_status

// File: dv/hfs_host_model.sv
// host side model: single byte register reads and writes
`timescale 1ns/10ps
module hfs_host_model (
	// clock
	input wire logic mclk,
	// register access
	output logic host_wr,
	output logic host_rd,
	output logic [7:0] host_addr,
	output logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata
);
	initial begin
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = 8'h00;
		host_wdata = 8'h00;
	end
	// idle address shows the inverse so a stale value is never trusted
	task automatic acc(input logic w, input logic [7:0] a,
		output logic [7:0] d);
		host_wr = w;
		host_rd = !w;
		host_addr = a;
		host_wdata = 8'h5A;
		@(posedge mclk);
		#1;
		d = host_rdata;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = ~a;
		host_wdata = 8'hA5;
		// one idle edge keeps back-to-back accesses apart
		@(posedge mclk);
		#1;
	endtask : acc
endmodule : hfs_host_model

// File: dv/tb_top.sv
// self-checking bench for the fault status block
`timescale 1ns/10ps
module tb_top;
	logic mclk, srst, init_done, fatal_irq, err_wr, boot_stage, irq_req;
	logic warm_reset, cfg_retained, host_wr, host_rd, reset_fault;
	logic host_irq, err_event, clk_en;
	logic [7:0] host_addr, host_wdata, host_rdata, err_code, err_value, d;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	hfs_fault_status u_dut (.mclk(mclk), .srst(srst), .clk_en(clk_en),
		.host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(host_rdata),
		.init_done(init_done), .fatal_irq(fatal_irq), .err_wr(err_wr),
		.err_code(err_code), .boot_stage(boot_stage), .irq_req(irq_req),
		.warm_reset(warm_reset), .cfg_retained(cfg_retained),
		.reset_fault(reset_fault), .host_irq(host_irq),
		.err_event(err_event), .err_value(err_value));
	hfs_host_model u_host (.mclk(mclk), .host_wr(host_wr),
		.host_rd(host_rd), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(host_rdata));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic complete_run();
		$display("n_fail %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	// run is far shorter than this
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t flag got %b want %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask : tick
	task automatic do_reset(input logic w);
		srst = 1'b1;
		warm_reset = w;
		cfg_retained = w;
		repeat (6) tick();
		srst = 1'b0;
		tick();
		tick();
		chk_bit(reset_fault, 1'b1);
		chk(err_value, 8'h00);
	endtask : do_reset
	task automatic t_boot();
		irq_req = 1'b1;
		repeat (3) tick();
		chk_bit(host_irq, 1'b0);
		u_host.acc(1'b1, 8'h07, d);
		tick();
		chk_bit(host_irq, 1'b1);
		irq_req = 1'b0;
		u_host.acc(1'b0, 8'h2D, d);
		chk(d, 8'h80);
		init_done = 1'b1;
		tick();
		tick();
		chk_bit(reset_fault, 1'b0);
		chk_bit(host_irq, 1'b0);
	endtask : t_boot
	task automatic t_fatal();
		fatal_irq = 1'b1;
		tick();
		fatal_irq = 1'b0;
		chk_bit(reset_fault, 1'b1);
		chk_bit(host_irq, 1'b1);
	endtask : t_fatal
	task automatic wr_err(input logic [7:0] c, input logic [7:0] v,
		input logic e);
		err_wr = 1'b1;
		err_code = c;
		tick();
		err_wr = 1'b0;
		chk(err_value, v);
		chk_bit(err_event, e);
		tick();
		chk_bit(err_event, 1'b0);
	endtask : wr_err
	task automatic t_err();
		for (logic [7:0] c = 8'h10; c < 8'h1E; c++)
			wr_err(c, c, c != 8'h18);
		u_host.acc(1'b1, 8'h2E, d);
		u_host.acc(1'b0, 8'h2E, d);
		chk(d, 8'h1D);
		u_host.acc(1'b0, 8'h30, d);
		chk(d, 8'h00);
		wr_err(8'h00, 8'h00, 1'b0);
		boot_stage = 1'b1;
		wr_err(8'h1A, 8'h00, 1'b0);
		wr_err(8'h19, 8'h19, 1'b1);
		wr_err(8'h1D, 8'h19, 1'b0);
		boot_stage = 1'b0;
	endtask : t_err
	task automatic t_freeze();
		clk_en = 1'b0;
		err_wr = 1'b1;
		err_code = 8'h12;
		tick();
		err_wr = 1'b0;
		clk_en = 1'b1;
		chk(err_value, 8'h19);
		chk_bit(err_event, 1'b0);
	endtask : t_freeze
	task automatic t_warm();
		do_reset(1'b1);
		irq_req = 1'b1;
		tick();
		tick();
		chk_bit(host_irq, 1'b1);
		irq_req = 1'b0;
	endtask : t_warm
	initial begin
		{init_done, fatal_irq, err_wr, boot_stage, irq_req} = 5'h00;
		err_code = 8'h00;
		clk_en = 1'b1;
		#1;
		do_reset(1'b0);
		t_boot();
		t_fatal();
		t_err();
		t_freeze();
		init_done = 1'b0;
		t_warm();
		complete_run();
	end
endmodule : tb_top
